// ==== verilog/udc_pkg.sv ====
// Shared constants and types for the upconverter mode and datapath block
package udc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FTW = 8'h04;
   localparam logic [7:0] OFS_ASF = 8'h08;
   localparam logic [7:0] OFS_STEP = 8'h0C;
   localparam logic [7:0] OFS_UPD = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   localparam logic [7:0] OFS_AMP = 8'h18;
   // Widths of the datapath
   localparam int PAR_W = 18;
   localparam int SER_W = 16;
   localparam int DAC_W = 14;
   localparam int ASF_W = 14;
   localparam int FTW_W = 32;
   localparam int STEP_W = 16;
   localparam int CTL_W = 6;
   // Part-selects of products and phase
   localparam int MOD_MSB = 31;
   localparam int MOD_LSB = 14;
   localparam int DAC_MSB = 31;
   localparam int DAC_LSB = 18;
   localparam int PH_MSB = 31;
   localparam int PH_LSB = 26;
   // Smoothing shifts: a larger one-pole shift makes dual serial smoother
   localparam int SMOOTH_NORM = 1;
   localparam int SMOOTH_DUAL = 3;
   // Reset values and counts
   localparam logic [ASF_W-1:0] RST_ASF = 14'h3FFF;
   localparam logic [STEP_W-1:0] RST_STEP = 16'h0001;
   localparam logic [3:0] SER_LAST = 4'hF;
   localparam logic [5:0] PH_QUARTER = 6'h10;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Operating modes, Gray coded
   typedef enum logic [1:0] {
      UDC_QUAD = 2'b00,
      UDC_INTERP = 2'b01,
      UDC_TONE = 2'b11
   } udc_mode_e;
   // Control word: mode [5:4], dual [3], inv sinc [2], sine sel [1], keying en [0]
   typedef struct packed {
      udc_mode_e mode;
      logic dual;
      logic inv_sinc;
      logic sine_sel;
      logic osk_en;
   } udc_ctl_s;
   // First quarter of a sine, 16 points, full scale 8191
   localparam logic [13:0] SIN_TBL [16] = '{
      14'h0000, 14'h0323, 14'h063E, 14'h094A, 14'h0C3F, 14'h0F15, 14'h11C7, 14'h144C,
      14'h16A0, 14'h18BC, 14'h1A9B, 14'h1C38, 14'h1D90, 14'h1E9F, 14'h1F63, 14'h1FD9};
endpackage

// ==== verilog/udc_mode_datapath.sv ====
// Mode control and datapath of the quadrature upconverter, with AXI4-Lite registers
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module udc_mode_datapath (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Baseband data port
   input wire logic port_data_clock,
   input wire logic tx_enable,
   input wire logic [udc_pkg::PAR_W-1:0] par_data,
   input wire logic ser_i_bit,
   input wire logic ser_q_bit,
   input wire logic upd_strobe,
   input wire logic keying,
   // Converter word
   output logic [udc_pkg::DAC_W-1:0] dac_word
);
   import udc_pkg::*;

   typedef struct packed {
      logic [2:0] port_data_clock_sy;
      logic [1:0] txen_sy;
      logic [1:0] upd_sy;
      logic [1:0] seri_sy;
      logic [1:0] serq_sy;
      logic [1:0] key_sy;
      logic [PAR_W-1:0] data_s1;
      logic [PAR_W-1:0] data_s2;
      logic txen_d;
      udc_ctl_s ctl_buf;
      udc_ctl_s ctl_act;
      logic [FTW_W-1:0] ftw_buf;
      logic [FTW_W-1:0] ftw_act;
      logic [ASF_W-1:0] asf_buf;
      logic [ASF_W-1:0] asf_act;
      logic [STEP_W-1:0] step_buf;
      logic [STEP_W-1:0] step_act;
      logic word_is_q;
      logic [PAR_W-1:0] i_hold;
      logic [PAR_W-1:0] held_i;
      logic [PAR_W-1:0] held_q;
      logic [PAR_W-1:0] filt_i;
      logic [PAR_W-1:0] filt_q;
      logic [3:0] bit_cnt;
      logic [SER_W-1:0] sh_i;
      logic [SER_W-1:0] sh_q;
      logic [FTW_W-1:0] phase;
      logic [ASF_W-1:0] amp;
      logic [STEP_W-1:0] tick;
      logic [PAR_W-1:0] x1;
      logic [PAR_W-1:0] x2;
      logic [DAC_W-1:0] dac;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr_q;
      logic [31:0] wdata_q;
      logic [3:0] wstrb_q;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } udc_st_s;

   udc_st_s st_ff;
   udc_st_s nxt_st;
   logic pd_edge;
   logic txen_rise;
   logic do_upd;
   logic restart;
   logic [31:0] merged;
   logic [ASF_W-1:0] scale;
   logic signed [14:0] cos_w;
   logic signed [14:0] sin_w;
   logic signed [32:0] prod_i;
   logic signed [32:0] prod_q;
   logic signed [33:0] mod_sum;
   logic signed [PAR_W-1:0] sig;
   logic signed [19:0] isinc;
   logic signed [PAR_W-1:0] post;
   logic signed [32:0] scaled;
   logic signed [PAR_W:0] diff_i;
   logic signed [PAR_W:0] diff_q;
   int smooth;

   // Merge write data into an old word by byte lane
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Sine from six phase bits by quarter-wave folding
   function automatic logic signed [14:0] wave(input logic [5:0] ph);
      logic [3:0] idx;
      logic [14:0] mag;
      idx = ph[4] ? ~ph[3:0] : ph[3:0];
      mag = {1'b0, SIN_TBL[idx]};
      return ph[5] ? $signed(-mag) : $signed(mag);
   endfunction

   // Register read mux; reserved bits and unmapped words read zero
   function automatic logic [31:0] reg_read(input udc_st_s s, input logic [7:0] a);
      case (a)
         OFS_CTRL: reg_read = 32'(s.ctl_buf);
         OFS_FTW: reg_read = s.ftw_buf;
         OFS_ASF: reg_read = 32'(s.asf_buf);
         OFS_STEP: reg_read = 32'(s.step_buf);
         OFS_STAT: reg_read = 32'({s.word_is_q, s.ctl_act});
         OFS_AMP: reg_read = 32'(s.amp);
         default: reg_read = 32'h0000_0000;
      endcase
   endfunction

   // Whole next state in one place
   always_comb begin
      nxt_st = st_ff;
      merged = 32'h0000_0000;
      do_upd = 1'b0;
      restart = 1'b0;
      // Two-stage synchronisers; stage one feeds stage two only
      nxt_st.port_data_clock_sy = {st_ff.port_data_clock_sy[1:0], port_data_clock};
      nxt_st.txen_sy = {st_ff.txen_sy[0], tx_enable};
      nxt_st.upd_sy = {st_ff.upd_sy[0], upd_strobe};
      nxt_st.seri_sy = {st_ff.seri_sy[0], ser_i_bit};
      nxt_st.serq_sy = {st_ff.serq_sy[0], ser_q_bit};
      nxt_st.key_sy = {st_ff.key_sy[0], keying};
      nxt_st.data_s1 = par_data;
      nxt_st.data_s2 = st_ff.data_s1;
      pd_edge = st_ff.port_data_clock_sy[1] & ~st_ff.port_data_clock_sy[2];
      txen_rise = st_ff.txen_sy[1] & ~st_ff.txen_d;
      if (pd_edge) begin
         nxt_st.txen_d = st_ff.txen_sy[1];
      end

      // Write channel: address and data taken in either order
      if (st_ff.awready && awvalid) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr_q = awaddr;
      end
      if (st_ff.wready && wvalid) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata_q = wdata;
         nxt_st.wstrb_q = wstrb;
      end
      if (st_ff.bvalid && bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (nxt_st.aw_got && nxt_st.w_got && !st_ff.bvalid) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         merged = lane_merge(reg_read(st_ff, nxt_st.awaddr_q), nxt_st.wdata_q, nxt_st.wstrb_q);
         case (nxt_st.awaddr_q)
            OFS_CTRL: nxt_st.ctl_buf = udc_ctl_s'(merged[CTL_W-1:0]);
            OFS_FTW: nxt_st.ftw_buf = merged;
            OFS_ASF: nxt_st.asf_buf = merged[ASF_W-1:0];
            OFS_STEP: nxt_st.step_buf = merged[STEP_W-1:0];
            OFS_UPD: do_upd = nxt_st.wstrb_q[0] & nxt_st.wdata_q[0];
            OFS_STAT, OFS_AMP: nxt_st.bresp = RESP_OKAY;
            default: nxt_st.bresp = RESP_SLVERR;
         endcase
      end
      nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
      nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

      // Read channel: one read in flight, answer the cycle after the address
      if (st_ff.rvalid && rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (st_ff.arready && arvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = reg_read(st_ff, araddr);
         nxt_st.rresp = (araddr <= OFS_AMP && araddr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
      end
      nxt_st.arready = !nxt_st.rvalid;

      // Transfer strobe, sampled at the port clock edge it is timed to
      do_upd = do_upd | (pd_edge & st_ff.upd_sy[1]);
      if (do_upd) begin
         nxt_st.ctl_act = st_ff.ctl_buf;
         nxt_st.ftw_act = st_ff.ftw_buf;
         nxt_st.asf_act = st_ff.asf_buf;
         nxt_st.step_act = st_ff.step_buf;
         restart = (st_ff.ctl_buf.mode != st_ff.ctl_act.mode) ||
                   (st_ff.ctl_buf.dual != st_ff.ctl_act.dual);
      end

      // Word capture; a new burst or a mode change starts at the I word
      if (restart) begin
         nxt_st.word_is_q = 1'b0;
         nxt_st.bit_cnt = 4'h0;
         nxt_st.held_i = '0;
         nxt_st.held_q = '0;
      end else if (pd_edge && st_ff.txen_sy[1]) begin
         if (txen_rise) begin
            nxt_st.word_is_q = 1'b0;
            nxt_st.bit_cnt = 4'h0;
         end
         case (st_ff.ctl_act.mode)
            UDC_QUAD: begin
               if (st_ff.ctl_act.dual) begin
                  // Serial frames, MSB first, one bit per port clock edge
                  nxt_st.sh_i = {st_ff.sh_i[SER_W-2:0], st_ff.seri_sy[1]};
                  nxt_st.sh_q = {st_ff.sh_q[SER_W-2:0], st_ff.serq_sy[1]};
                  nxt_st.bit_cnt = nxt_st.bit_cnt + 4'h1;
                  if (nxt_st.bit_cnt == 4'h0) begin
                     nxt_st.held_i = {nxt_st.sh_i, 2'b00};
                     nxt_st.held_q = {nxt_st.sh_q, 2'b00};
                  end
               end else if (!nxt_st.word_is_q) begin
                  nxt_st.i_hold = st_ff.data_s2;
                  nxt_st.word_is_q = 1'b1;
               end else begin
                  nxt_st.held_i = st_ff.i_hold;
                  nxt_st.held_q = st_ff.data_s2;
                  nxt_st.word_is_q = 1'b0;
               end
            end
            UDC_INTERP: begin
               nxt_st.held_i = st_ff.data_s2;
               nxt_st.held_q = '0;
            end
            default: begin
               nxt_st.held_i = '0;
               nxt_st.held_q = '0;
            end
         endcase
      end

      // Held samples repeat each captured input word until the next capture;
      // one-pole smoothing suppresses images, stronger in dual serial
      smooth = st_ff.ctl_act.dual ? SMOOTH_DUAL : SMOOTH_NORM;
      diff_i = 19'($signed(nxt_st.held_i)) - 19'($signed(st_ff.filt_i));
      diff_q = 19'($signed(nxt_st.held_q)) - 19'($signed(st_ff.filt_q));
      nxt_st.filt_i = 18'($signed(st_ff.filt_i) + 18'(diff_i >>> smooth));
      nxt_st.filt_q = 18'($signed(st_ff.filt_q) + 18'(diff_q >>> smooth));
      if (st_ff.ctl_act.mode != UDC_QUAD) begin
         nxt_st.filt_q = '0;
      end
      if (st_ff.ctl_act.mode == UDC_TONE) begin
         nxt_st.filt_i = '0;
      end

      // Synthesizer runs except in interpolating mode
      if (st_ff.ctl_act.mode == UDC_INTERP) begin
         nxt_st.phase = '0;
      end else begin
         nxt_st.phase = st_ff.phase + st_ff.ftw_act;
      end
      sin_w = wave(st_ff.phase[PH_MSB:PH_LSB]);
      cos_w = wave(st_ff.phase[PH_MSB:PH_LSB] + PH_QUARTER);

      // Modulator and mode routing
      prod_i = $signed(st_ff.filt_i) * cos_w;
      prod_q = $signed(st_ff.filt_q) * sin_w;
      mod_sum = 34'(prod_i) + 34'(prod_q);
      case (st_ff.ctl_act.mode)
         UDC_QUAD: sig = mod_sum[MOD_MSB:MOD_LSB];
         UDC_INTERP: sig = $signed(st_ff.filt_i);
         UDC_TONE: sig = st_ff.ctl_act.sine_sel ? $signed({sin_w, 3'b000}) :
                                                  $signed({cos_w, 3'b000});
         default: sig = '0;
      endcase

      // Three-tap inverse sinc, bypassed with equal latency
      nxt_st.x1 = sig;
      nxt_st.x2 = st_ff.x1;
      isinc = 20'($signed(st_ff.x1)) + 20'($signed(st_ff.x1) >>> 3) - 20'(sig >>> 4) -
              20'($signed(st_ff.x2) >>> 4);
      post = st_ff.ctl_act.inv_sinc ? isinc[PAR_W-1:0] : $signed(st_ff.x1);

      // Output keying ramps one step per programmed interval
      if (st_ff.ctl_act.mode == UDC_TONE && st_ff.ctl_act.osk_en) begin
         nxt_st.tick = st_ff.tick + 16'h0001;
         if (st_ff.tick >= st_ff.step_act) begin
            nxt_st.tick = '0;
            if (st_ff.amp > st_ff.asf_act) begin
               nxt_st.amp = st_ff.asf_act;
            end else if (st_ff.key_sy[1] && st_ff.amp < st_ff.asf_act) begin
               nxt_st.amp = st_ff.amp + 14'h0001;
            end else if (!st_ff.key_sy[1] && st_ff.amp != '0) begin
               nxt_st.amp = st_ff.amp - 14'h0001;
            end
         end
      end else begin
         nxt_st.tick = '0;
         nxt_st.amp = st_ff.asf_act;
      end

      // Output scaling multiplier to the converter word
      scale = (st_ff.ctl_act.mode == UDC_TONE && st_ff.ctl_act.osk_en) ? st_ff.amp :
                                                                      st_ff.asf_act;
      scaled = post * $signed({1'b0, scale});
      nxt_st.dac = scaled[DAC_MSB:DAC_LSB];
   end

   // Synchronous reset; low enable freezes every bit of state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.asf_buf <= RST_ASF;
         st_ff.asf_act <= RST_ASF;
         st_ff.step_buf <= RST_STEP;
         st_ff.step_act <= RST_STEP;
         st_ff.amp <= RST_ASF;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs come straight from state
   assign awready = st_ff.awready;
   assign wready = st_ff.wready;
   assign bresp = st_ff.bresp;
   assign bvalid = st_ff.bvalid;
   assign arready = st_ff.arready;
   assign rdata = st_ff.rdata;
   assign rresp = st_ff.rresp;
   assign rvalid = st_ff.rvalid;
   assign dac_word = st_ff.dac;
endmodule

// ==== verification/udc_mode_datapath_assertions.sv ====
// Port-level timing checks for the upconverter mode and datapath block
`timescale 1ns/100ps
module udc_mode_datapath_assertions (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write channels
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   // Read channels
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // Converter word
   input wire logic [udc_pkg::DAC_W-1:0] dac_word
);
   import udc_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Both write halves taken at one edge, as the bench offers them
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rd_taken;
      arvalid && arready;
   endsequence
   chk_reset_quiet: assert property ($rose(aresetn) |-> !bvalid && !rvalid && dac_word == '0)
      else $error("outputs not idle after reset");
   chk_write_answer: assert property (s_wr_taken |=> bvalid && !awready && !wready)
      else $error("write response missing");
   chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   chk_bvalid_drop: assert property (bvalid && bready |=> !bvalid ##[0:1] (awready && wready))
      else $error("write channel did not recover");
   chk_read_answer: assert property (s_rd_taken |=> rvalid && !arready)
      else $error("read data missing");
   chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data changed while waiting");
   chk_rvalid_drop: assert property (rvalid && rready |=> !rvalid ##[0:1] arready)
      else $error("read channel did not recover");
   chk_err_data: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == '0)
      else $error("refused read carries data");
   chk_one_write: assert property (bvalid |-> !awready && !wready)
      else $error("second write accepted too early");
endmodule

bind udc_mode_datapath udc_mode_datapath_assertions udc_mode_datapath_assertions_i (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
   .rready(rready), .dac_word(dac_word));

// ==== verification/udc_source.sv ====
// Behavioural baseband data source on the far side of the data port
`timescale 1ns/100ps
module udc_source (
   // Data port pins
   output logic port_data_clock,
   output logic tx_enable,
   output logic [udc_pkg::PAR_W-1:0] par_data,
   output logic ser_i_bit,
   output logic ser_q_bit,
   output logic upd_strobe
);
   import udc_pkg::*;
   // Idle pins; the port clock stands still outside frames
   initial begin
      port_data_clock = 1'b0;
      tx_enable = 1'b0;
      par_data = '0;
      ser_i_bit = 1'b0;
      ser_q_bit = 1'b0;
      upd_strobe = 1'b0;
   end
   // One 320 ns port clock cycle, pins steady four system cycles around the rise
   task automatic edge_out(input logic [PAR_W-1:0] w, input logic en, input logic st,
      input logic si, input logic sq);
      par_data <= w;
      tx_enable <= en;
      upd_strobe <= st;
      ser_i_bit <= si;
      ser_q_bit <= sq;
      #160;
      port_data_clock <= 1'b1;
      #160;
      port_data_clock <= 1'b0;
   endtask
   // Released lines flip so a stale word never passes for a fresh one
   task automatic release_pins();
      par_data <= ~par_data;
      ser_i_bit <= ~ser_i_bit;
      ser_q_bit <= ~ser_q_bit;
      upd_strobe <= 1'b0;
   endtask
   // Parallel words: caller alternates I then Q
   task automatic send_par(input logic [PAR_W-1:0] w);
      edge_out(w, 1'b1, 1'b0, 1'b0, 1'b0);
      release_pins();
   endtask
   // Two serial streams of 16 bits, MSB first
   task automatic send_ser(input logic [SER_W-1:0] iw, input logic [SER_W-1:0] qw);
      for (int b = SER_W - 1; b >= 0; b--) begin
         edge_out('0, 1'b1, 1'b0, iw[b], qw[b]);
      end
      release_pins();
   endtask
   // Transfer strobe on a port clock edge
   task automatic strobe();
      edge_out('0, tx_enable, 1'b1, 1'b0, 1'b0);
      release_pins();
   endtask
endmodule

// ==== verification/tb_udc_mode_datapath.sv ====
// Self-checking bench for the upconverter mode and datapath block
`timescale 1ns/100ps
module tb_udc_mode_datapath;
   import udc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdata, d;
   logic awready, wready, bvalid, arready, rvalid, keying = 1'b1, seen, ce = 1'b1;
   logic [1:0] bresp, rresp;
   logic [DAC_W-1:0] dac_word;
   logic port_data_clock, tx_enable, ser_i_bit, ser_q_bit, upd_strobe;
   logic [PAR_W-1:0] par_data;
   logic [5:0] act, nx;
   int failures = 0, compares = 0, seed = 77;
   udc_mode_e modes [3] = '{UDC_QUAD, UDC_INTERP, UDC_TONE};
   // 25 MHz, far below the dual serial ceiling
   always #20 aclk = ~aclk;
   udc_mode_datapath udc_mode_datapath_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .port_data_clock(port_data_clock), .tx_enable(tx_enable), .par_data(par_data),
      .ser_i_bit(ser_i_bit), .ser_q_bit(ser_q_bit), .upd_strobe(upd_strobe),
      .keying(keying), .dac_word(dac_word));
   udc_source udc_source_i (.port_data_clock(port_data_clock), .tx_enable(tx_enable),
      .par_data(par_data), .ser_i_bit(ser_i_bit), .ser_q_bit(ser_q_bit),
      .upd_strobe(upd_strobe));
   // Compare and count
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Verdict and end of run
   task automatic complete_run();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Bus write; both halves offered together, bready held until the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Only the watchdog ends a wait that never sees the answer
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      check(bresp, er);
      bready <= 1'b0;
   endtask
   // Bus read, masked compare of data and answer code
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      check(rdata & m, e);
      check(rresp, er);
      rready <= 1'b0;
   endtask
   // Expected status word from the active control bits
   function automatic logic [31:0] stat(input logic [5:0] c, input logic wait_q);
      return {25'h0, wait_q, c};
   endfunction
   // Hang guard, sized well beyond the sequence below
   initial begin
      #2000000;
      failures++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, quadrature mode active by default
      rc(OFS_CTRL, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
      rc(OFS_ASF, 32'h3FFF, RST_ASF, RESP_OKAY);
      rc(OFS_STEP, 32'hFFFF, RST_STEP, RESP_OKAY);
      rc(OFS_STAT, 32'h7F, stat(6'h00, 1'b0), RESP_OKAY);
      rc(8'h1C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
      rc(8'h02, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
      wr(8'h40, 32'h1, RESP_SLVERR);
      // Random tuning words read back from the buffer
      for (int k = 0; k < 3; k++) begin
         d = $random(seed);
         wr(OFS_FTW, d, RESP_OKAY);
         rc(OFS_FTW, 32'hFFFFFFFF, d, RESP_OKAY);
      end
      // Every mode, held in the buffer until a transfer
      act = 6'h00;
      for (int k = 0; k < 3; k++) begin
         nx = {modes[k], 1'b0, 3'($random(seed))};
         wr(OFS_CTRL, {26'h0, nx}, RESP_OKAY);
         rc(OFS_STAT, 32'h3F, {26'h0, act}, RESP_OKAY);
         wr(OFS_UPD, 32'h1, RESP_OKAY);
         act = nx;
         rc(OFS_STAT, 32'h7F, stat(act, 1'b0), RESP_OKAY);
      end
      // Transfer by the strobe pin, back to quadrature
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      udc_source_i.strobe();
      rc(OFS_STAT, 32'h7F, stat(6'h00, 1'b0), RESP_OKAY);
      // I then Q pairing, and restart at I on a dual serial change
      udc_source_i.send_par(18'($random(seed)));
      rc(OFS_STAT, 32'h7F, stat(6'h00, 1'b1), RESP_OKAY);
      udc_source_i.send_par(18'($random(seed)));
      rc(OFS_STAT, 32'h7F, stat(6'h00, 1'b0), RESP_OKAY);
      udc_source_i.send_par(18'($random(seed)));
      // Carrier steps one table point per cycle, so the sweep reaches its peak
      wr(OFS_FTW, 32'h0400_0000, RESP_OKAY);
      wr(OFS_CTRL, 32'h08, RESP_OKAY);
      wr(OFS_UPD, 32'h1, RESP_OKAY);
      rc(OFS_STAT, 32'h7F, stat(6'h08, 1'b0), RESP_OKAY);
      udc_source_i.send_ser(16'h4000, 16'h2000);
      seen = 1'b0;
      repeat (48) begin
         @(posedge aclk);
         seen = seen | (dac_word[13:8] != 6'h00 && dac_word[13:8] != 6'h3F);
      end
      check(seen, 1'b1);
      // Interpolating: every word a sample, zero input gives zero output
      wr(OFS_CTRL, 32'h10, RESP_OKAY);
      wr(OFS_UPD, 32'h1, RESP_OKAY);
      udc_source_i.send_par(18'h0);
      rc(OFS_STAT, 32'h7F, stat(6'h10, 1'b0), RESP_OKAY);
      repeat (60) @(posedge aclk);
      check(dac_word, 14'h0);
      // Positive half scale word at full scale AMPLITUDE_SCALE_WORD lands just under 0x1000
      udc_source_i.send_par(18'h10000);
      repeat (60) @(posedge aclk);
      check(dac_word, 14'h0FFF);
      // Tone with zero amplitude word, port words ignored
      wr(OFS_ASF, 32'h0, RESP_OKAY);
      wr(OFS_CTRL, 32'h30, RESP_OKAY);
      wr(OFS_UPD, 32'h1, RESP_OKAY);
      udc_source_i.send_par(18'h1FFFF);
      rc(OFS_STAT, 32'h7F, stat(6'h30, 1'b0), RESP_OKAY);
      repeat (20) @(posedge aclk);
      check(dac_word, 14'h0);
      // Keying ramps between zero and the preset
      wr(OFS_ASF, 32'h10, RESP_OKAY);
      wr(OFS_STEP, 32'h1, RESP_OKAY);
      wr(OFS_CTRL, 32'h31, RESP_OKAY);
      wr(OFS_UPD, 32'h1, RESP_OKAY);
      keying <= 1'b0;
      repeat (60) @(posedge aclk);
      rc(OFS_AMP, 32'h3FFF, 32'h0, RESP_OKAY);
      // Enable low freezes the ramp even with keying raised
      keying <= 1'b1;
      ce <= 1'b0;
      repeat (60) @(posedge aclk);
      ce <= 1'b1;
      rc(OFS_AMP, 32'h3FFF, 32'h0, RESP_OKAY);
      repeat (60) @(posedge aclk);
      rc(OFS_AMP, 32'h3FFF, 32'h10, RESP_OKAY);
      complete_run();
   end
endmodule
